/* File: dv/cfr_cmd_checker.sv */
// Purpose: concurrent checks on the ports of cfr_cmd
// Assumes: one clock, asynchronous active-low reset
// Notes:   response byte position is counted from accepted tx beats
module cfr_cmd_checker (
    // clock and reset
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    // command stream
    input wire logic [7:0]  rx_data_i,
    input wire logic        rx_valid_i,
    input wire logic        rx_ready_o,
    // response stream
    input wire logic [7:0]  tx_data_o,
    input wire logic        tx_valid_o,
    input wire logic        tx_ready_i,
    // storage request
    input wire logic        file_req_o,
    input wire logic [1:0]  file_sel_o,
    input wire logic [31:0] file_len_o,
    input wire logic [7:0]  status_o
);
    logic [5:0] tcnt_q;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // wraps every 64 beats, so it stays aligned only while frames are whole
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            tcnt_q <= 6'h00;
        else if (tx_valid_o && tx_ready_i)
            tcnt_q <= tcnt_q + 6'h01;
    end

    chk_marker_high: assert property (
        tx_valid_o && tcnt_q == 6'h00 |-> tx_data_o == 8'ha1) else $error("marker high byte");
    chk_marker_low: assert property (
        tx_valid_o && tcnt_q == 6'h01 |-> tx_data_o == 8'hec) else $error("marker low byte");
    chk_version_out: assert property (
        tx_valid_o && tcnt_q == 6'h02 |-> tx_data_o == 8'h03) else $error("version byte");
    chk_len_zero: assert property (
        tx_valid_o && tcnt_q inside {[6'h08:6'h0b]} |-> tx_data_o == 8'h00)
        else $error("length not zero");
    chk_pcs_zero: assert property (
        tx_valid_o && tcnt_q inside {[6'h3a:6'h3d]} |-> tx_data_o == 8'h00)
        else $error("data checksum not zero");
    chk_status_echo: assert property (
        tx_valid_o && tcnt_q == 6'h05 |-> tx_data_o == status_o) else $error("status byte");
    chk_tx_hold: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) else $error("tx dropped");
    chk_req_good: assert property (
        file_req_o |-> status_o == cfr_pkg::RES_OK && !rx_ready_o) else $error("bad request");
    chk_req_pulse: assert property (
        file_req_o |=> !file_req_o) else $error("request not a pulse");
    chk_sel_known: assert property (
        file_req_o |-> file_sel_o != 2'h3) else $error("unknown selection");
    chk_rx_gap: assert property (
        rx_ready_o |-> tcnt_q == 6'h00 || tcnt_q >= 6'h3e) else $error("rx open mid response");
endmodule

/* File: dv/cfr_host.sv */
// Purpose: host on the control link: sends command frames, collects responses
// Assumes: signals change on the falling edge only
// Notes:   slow makes the host stall the response stream for long stretches
module cfr_host (
    // clock
    input wire logic        sys_clk_i,
    // command stream
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    input wire logic        rx_ready_i,
    // response stream
    input wire logic [7:0]  tx_data_i,
    input wire logic        tx_valid_i,
    output logic            tx_ready_o
);
    logic [7:0] resp[$];
    logic       slow = 1'b0;
    logic       busy = 1'b0;
    logic [2:0] cyc  = 3'h0;

    initial
    begin
        rx_data_o  = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b1;
    end

    // idle data keeps changing so a stray sample never looks like a byte
    always @(negedge sys_clk_i)
    begin
        cyc <= cyc + 3'h1;
        tx_ready_o <= !slow || cyc == 3'h7;
        if (!busy)
            rx_data_o <= ~rx_data_o;
    end

    always @(posedge sys_clk_i)
        if (tx_valid_i && tx_ready_o)
            resp.push_back(tx_data_i);

    // bytes go out back to back, each held until taken
    task automatic send(input logic [7:0] f[$]);
        busy = 1'b1;
        @(posedge sys_clk_i);
        foreach (f[i])
        begin
            @(negedge sys_clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o  <= f[i];
            @(posedge sys_clk_i);
            while (!rx_ready_i) @(posedge sys_clk_i);
        end
        @(negedge sys_clk_i);
        rx_valid_o <= 1'b0;
        busy = 1'b0;
    endtask
endmodule

/* File: dv/tb_cfr_cmd.sv */
// Purpose: self-checking bench for cfr_cmd
// Assumes: host model drives the command stream and takes the response
// Notes:   checksums are recomputed here bit by bit
module tb_cfr_cmd;
    timeunit 1ns;
    timeprecision 1ns;
    typedef logic [7:0] cfr_bytes_t[$];
    logic        sys_clk_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic [7:0]  rx_data_i;
    logic        rx_valid_i;
    logic        rx_ready_o;
    logic [7:0]  tx_data_o;
    logic        tx_valid_o;
    logic        tx_ready_i;
    logic        file_req_o;
    logic [1:0]  file_sel_o;
    logic [31:0] file_len_o;
    logic [7:0]  status_o;
    int          mismatches = 0;
    int          compares   = 0;
    int          reqs       = 0;

    always #50 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (file_req_o) reqs++;

    cfr_cmd u_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .rx_data_i(rx_data_i),
        .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o),
        .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .file_req_o(file_req_o),
        .file_sel_o(file_sel_o), .file_len_o(file_len_o), .status_o(status_o));
    cfr_host u_host (.sys_clk_i(sys_clk_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
        .rx_ready_i(rx_ready_o), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
        .tx_ready_o(tx_ready_i));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic logic [15:0] c16(cfr_bytes_t b);
        logic [15:0] c = 16'h0000;
        for (int i = 2; i <= 61; i++)
            for (int k = 7; k >= 0; k--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction

    function automatic logic [31:0] c32(cfr_bytes_t b);
        logic [31:0] c = 32'hffffffff;
        foreach (b[i])
            for (int k = 7; k >= 0; k--)
                c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i][k]) ? 32'h04c11db7 : 32'h00000000);
        return c;
    endfunction

    // header fields high byte first, file size at offset eight
    function automatic cfr_bytes_t hdr(logic [15:0] pre, logic [7:0] ver, logic [7:0] cmd,
        logic [7:0] st, logic [15:0] flg, logic [31:0] len, logic [31:0] pcs, logic bad);
        cfr_bytes_t h;
        logic [15:0] c;
        for (int i = 0; i < 64; i++) h.push_back(8'h00);
        h[0] = pre[15:8];
        h[1] = pre[7:0];
        h[2] = ver;
        h[3] = cmd;
        h[4] = 8'h5a;
        h[5] = st;
        h[6] = flg[15:8];
        h[7] = flg[7:0];
        for (int k = 0; k < 4; k++)
        begin
            h[8 + k]  = len[31 - 8 * k -: 8];
            h[58 + k] = pcs[31 - 8 * k -: 8];
        end
        c = c16(h) ^ {15'h0000, bad};
        h[62] = c[15:8];
        h[63] = c[7:0];
        return h;
    endfunction

    task automatic run(cfr_bytes_t f, logic [7:0] st, logic [7:0] cmd, logic [31:0] len);
        cfr_bytes_t e;
        int r0;
        int n;
        r0 = reqs;
        n = 0;
        u_host.resp.delete();
        u_host.send(f);
        while (u_host.resp.size() < 64 && n < 2000)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        repeat (4) @(negedge sys_clk_i);
        e = hdr(16'ha1ec, 8'h03, cmd, st, 16'h0000, 32'h0, 32'h0, 1'b0);
        check(u_host.resp.size(), 32'd64);
        for (int i = 0; i < 64; i++) check(u_host.resp[i], e[i]);
        check(status_o, st);
        check(reqs - r0, st == cfr_pkg::RES_OK);
        if (st == cfr_pkg::RES_OK)
        begin
            check(file_sel_o, cmd - 8'h8d);
            check(file_len_o, len);
        end
    endtask

    task automatic t_good;
        cfr_bytes_t f;
        cfr_bytes_t d;
        for (int k = 0; k < 3; k++)
        begin
            d.delete();
            for (int i = 0; i < k + 1; i++) d.push_back(8'h31 + 8'(i * 17));
            if (k == 0) d.delete();
            // last one skips the data check and carries a wrong checksum on purpose
            f = hdr(16'ha1ec, 8'h03, 8'h8d + 8'(k), 8'hff, {15'h0000, k == 2}, d.size(),
                k == 2 ? 32'h0 : c32(d), 1'b0);
            f = {f, d};
            run(f, cfr_pkg::RES_OK, 8'h8d + 8'(k), d.size());
        end
    endtask

    task automatic t_bad_header;
        logic [15:0] pre[5] = '{16'ha1ed, 16'ha1ec, 16'ha1ec, 16'ha1ec, 16'h21ec};
        logic [7:0]  ver[5] = '{8'h03, 8'h04, 8'h03, 8'h03, 8'h03};
        logic [7:0]  cmd[5] = '{8'h8d, 8'h8e, 8'h8f, 8'h8c, 8'h8e};
        logic        bad[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        logic [7:0]  st[5]  = '{8'h02, 8'h03, 8'h01, 8'h04, 8'h01};
        // length is nonzero but no data follows: a bad header must not eat bytes
        // the unknown command keeps a sound header, so it goes without a length
        for (int i = 0; i < 5; i++)
            run(hdr(pre[i], ver[i], cmd[i], 8'h00, 16'h0, (i == 3) ? 32'h0 : 32'h4, 32'h0,
                bad[i]), st[i], cmd[i], 32'h0);
    endtask

    task automatic t_bad_pcs;
        cfr_bytes_t d = '{8'h10, 8'h20, 8'h30};
        run({hdr(16'ha1ec, 8'h03, 8'h8f, 8'h00, 16'h0, 32'h3, ~c32(d), 1'b0), d},
            cfr_pkg::RES_BAD_PCS, 8'h8f, 32'h3);
    endtask

    task automatic t_stall;
        u_host.slow = 1'b1;
        run(hdr(16'ha1ec, 8'h03, 8'h8e, 8'h00, 16'h0, 32'h0, 32'h0, 1'b0), cfr_pkg::RES_OK,
            8'h8e, 32'h0);
        u_host.slow = 1'b0;
    endtask

    initial
    begin
        #(20000 * 100);
        mismatches++;
        test_done();
    end

    initial
    begin
        repeat (10) @(negedge sys_clk_i);
        check({rx_ready_o, tx_valid_o, file_req_o, status_o}, 32'h0);
        resetn_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        t_good();
        t_bad_header();
        t_bad_pcs();
        t_stall();
        test_done();
    end
endmodule

bind cfr_cmd cfr_cmd_checker u_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .file_req_o(file_req_o), .file_sel_o(file_sel_o), .file_len_o(file_len_o),
    .status_o(status_o));

/* File: pkg/cfr_pkg.sv */
// Purpose: constants, encodings and checksum steps for the calibration file read handler
// Assumes: one byte per transfer on both streams, header fields sent high byte first
// Notes:   result codes other than success are local encodings of this block
// Behaviour
// RL1 - every frame opens with the two-byte start-of-header marker at offset zero
// RL2 - byte after the marker holds protocol version three, sent and expected
// RL3 - command byte at offset three picks depth, colour or extrinsic calibration
// RL4 - host puts the 32-bit file size at offset eight
// RL5 - flag bit zero set skips the data checksum; host keeps it clear
// RL6 - header checksum covers the sixty bytes from offset two through sixty-one
// RL7 - header checksum is 16-bit CCITT, polynomial 1021, start value zero
// RL8 - data checksum is 32-bit CRC, polynomial 04C11DB7, start value all ones
// RL9 - any file bytes follow the header from offset sixty-four, unbroken
// RL10 - response echoes the received command and sub-command bytes
// RL11 - response has no payload: length and data checksum fields are zero
// RL12 - multi-byte header fields travel most significant byte first
// RL13 - bad marker, version or header checksum gives a failing status and no action
package cfr_pkg;

    localparam logic [15:0] PREAMBLE      = 16'ha1ec;
    localparam logic [7:0]  PROTO_VERSION = 8'h03;
    localparam logic [7:0]  CMD_DEPTH_CAL = 8'h8d;
    localparam logic [7:0]  CMD_COLOR_CAL = 8'h8e;
    localparam logic [7:0]  CMD_EXTR_CAL  = 8'h8f;

    // header byte offsets
    localparam logic [5:0] OFS_PRE_HI   = 6'h00;
    localparam logic [5:0] OFS_PRE_LO   = 6'h01;
    localparam logic [5:0] OFS_VERSION  = 6'h02;
    localparam logic [5:0] OFS_CMD      = 6'h03;
    localparam logic [5:0] OFS_SUBCMD   = 6'h04;
    localparam logic [5:0] OFS_STATUS   = 6'h05;
    localparam logic [5:0] OFS_FLAGS_HI = 6'h06;
    localparam logic [5:0] OFS_FLAGS_LO = 6'h07;
    localparam logic [5:0] OFS_LEN_FRST = 6'h08;
    localparam logic [5:0] OFS_LEN_LAST = 6'h0b;
    localparam logic [5:0] OFS_PCS_FRST = 6'h3a;
    localparam logic [5:0] OFS_CRC_FRST = 6'h02;
    localparam logic [5:0] OFS_CRC_LAST = 6'h3d;
    localparam logic [5:0] OFS_HCS_HI   = 6'h3e;
    localparam logic [5:0] OFS_HCS_LO   = 6'h3f;

    localparam int unsigned FLAG_SKIP_PCS = 0;

    localparam logic [15:0] CRC16_POLY = 16'h1021;
    localparam logic [15:0] CRC16_INIT = 16'h0000;
    localparam logic [31:0] CRC32_POLY = 32'h04c11db7;
    localparam logic [31:0] CRC32_INIT = 32'hffffffff;

    // result codes
    localparam logic [7:0] RES_OK         = 8'h00;
    localparam logic [7:0] RES_BAD_HCS    = 8'h01;
    localparam logic [7:0] RES_BAD_PRE    = 8'h02;
    localparam logic [7:0] RES_BAD_VER    = 8'h03;
    localparam logic [7:0] RES_BAD_CMD    = 8'h04;
    localparam logic [7:0] RES_BAD_PCS    = 8'h05;

    localparam logic [1:0] SEL_DEPTH = 2'h0;
    localparam logic [1:0] SEL_COLOR = 2'h1;
    localparam logic [1:0] SEL_EXTR  = 2'h2;

    localparam int unsigned BUF_WIDTH = 8;

    typedef enum logic [2:0] {
        ST_RX_HDR,
        ST_HDR_CHK,
        ST_RX_DATA,
        ST_DECIDE,
        ST_TX_RESP
    } cfr_state_t;

    // one byte through the ccitt register, msb first
    function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {b, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            c = c[15] ? ((c << 1) ^ CRC16_POLY) : (c << 1);
        end
        return c;
    endfunction

    // one byte through the 32-bit register, msb first, no reflection
    function automatic logic [31:0] crc32_byte(input logic [31:0] crc, input logic [7:0] b);
        logic [31:0] c;
        c = crc ^ {b, 24'h000000};
        for (int i = 0; i < 8; i++)
        begin
            c = c[31] ? ((c << 1) ^ CRC32_POLY) : (c << 1);
        end
        return c;
    endfunction

endpackage

/* File: rtl/cfr_cmd.sv */
// Purpose: takes a calibration file read command frame, checks it, sends the response header
// Assumes: rx bytes come from logic on sys_clk_i, one byte per accepted beat
// Notes:   the storage read itself sits elsewhere; this block only raises a request pulse
module cfr_cmd (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // command byte stream in
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_valid_i,
    output logic             rx_ready_o,
    // response byte stream out
    output logic [7:0]       tx_data_o,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    // request to the storage side
    output logic             file_req_o,
    output logic [1:0]       file_sel_o,
    output logic [31:0]      file_len_o,
    output logic [7:0]       status_o
);

    cfr_pkg::cfr_state_t state_q;
    cfr_pkg::cfr_state_t state_d;

    logic        rx_ready_q;
    logic        rx_take;
    logic [5:0]  idx_q;
    logic [15:0] pre_q;
    logic [7:0]  ver_q;
    logic [7:0]  cmd_q;
    logic [7:0]  sub_q;
    logic [15:0] flags_q;
    logic [31:0] len_q;
    logic [31:0] pcs_q;
    logic [15:0] hcs_q;
    logic [15:0] crc16_q;
    logic [31:0] crc32_q;
    logic [31:0] data_cnt_q;
    logic        hdr_good;
    logic [7:0]  status_q;
    logic        file_req_q;
    logic [1:0]  file_sel_q;
    logic [31:0] file_len_q;

    logic [5:0]  tx_idx_q;
    logic [15:0] tx_crc_q;
    logic [7:0]  tx_byte;
    logic        tx_push;
    logic        buf_ready;

    logic        cmd_known;

    assign rx_take   = rx_valid_i && rx_ready_q;
    assign cmd_known = (cmd_q == cfr_pkg::CMD_DEPTH_CAL) || (cmd_q == cfr_pkg::CMD_COLOR_CAL)
                       || (cmd_q == cfr_pkg::CMD_EXTR_CAL);  // see RL3
    assign tx_push   = (state_q == cfr_pkg::ST_TX_RESP) && buf_ready;
    assign hdr_good  = (crc16_q == hcs_q) && (pre_q == cfr_pkg::PREAMBLE)
                       && (ver_q == cfr_pkg::PROTO_VERSION);  // see RL13

    // sequencing
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            cfr_pkg::ST_RX_HDR:
            begin
                if (rx_take && (idx_q == cfr_pkg::OFS_HCS_LO))
                    state_d = cfr_pkg::ST_HDR_CHK;
            end
            cfr_pkg::ST_HDR_CHK:
            begin
                // an untrusted header gives an untrusted length, so no data is consumed
                if (hdr_good && (len_q != 32'h00000000))
                    state_d = cfr_pkg::ST_RX_DATA;  // see RL9
                else
                    state_d = cfr_pkg::ST_DECIDE;
            end
            cfr_pkg::ST_RX_DATA:
            begin
                if (rx_take && (data_cnt_q == len_q - 32'h00000001))
                    state_d = cfr_pkg::ST_DECIDE;
            end
            cfr_pkg::ST_DECIDE:
            begin
                state_d = cfr_pkg::ST_TX_RESP;
            end
            cfr_pkg::ST_TX_RESP:
            begin
                if (tx_push && (tx_idx_q == cfr_pkg::OFS_HCS_LO))
                    state_d = cfr_pkg::ST_RX_HDR;
            end
            default:
            begin
                state_d = cfr_pkg::ST_RX_HDR;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q    <= cfr_pkg::ST_RX_HDR;
            rx_ready_q <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            rx_ready_q <= (state_d == cfr_pkg::ST_RX_HDR) || (state_d == cfr_pkg::ST_RX_DATA);
        end
    end

    // header capture, high byte first for every wide field
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            idx_q   <= 6'h00;
            pre_q   <= 16'h0000;
            ver_q   <= 8'h00;
            cmd_q   <= 8'h00;
            sub_q   <= 8'h00;
            flags_q <= 16'h0000;
            len_q   <= 32'h00000000;
            pcs_q   <= 32'h00000000;
            hcs_q   <= 16'h0000;
        end
        else if (rx_take && (state_q == cfr_pkg::ST_RX_HDR))
        begin
            idx_q <= idx_q + 6'h01;
            if (idx_q <= cfr_pkg::OFS_PRE_LO)
                pre_q <= {pre_q[7:0], rx_data_i};  // see RL1, RL12
            if (idx_q == cfr_pkg::OFS_VERSION)
                ver_q <= rx_data_i;
            if (idx_q == cfr_pkg::OFS_CMD)
                cmd_q <= rx_data_i;
            if (idx_q == cfr_pkg::OFS_SUBCMD)
                sub_q <= rx_data_i;
            if ((idx_q == cfr_pkg::OFS_FLAGS_HI) || (idx_q == cfr_pkg::OFS_FLAGS_LO))
                flags_q <= {flags_q[7:0], rx_data_i};
            if ((idx_q >= cfr_pkg::OFS_LEN_FRST) && (idx_q <= cfr_pkg::OFS_LEN_LAST))
                len_q <= {len_q[23:0], rx_data_i};  // see RL4, RL12
            if ((idx_q >= cfr_pkg::OFS_PCS_FRST) && (idx_q <= cfr_pkg::OFS_CRC_LAST))
                pcs_q <= {pcs_q[23:0], rx_data_i};
            if (idx_q >= cfr_pkg::OFS_HCS_HI)
                hcs_q <= {hcs_q[7:0], rx_data_i};
        end
    end

    // header checksum over offsets two to sixty-one
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            crc16_q <= cfr_pkg::CRC16_INIT;
        end
        else if (state_q == cfr_pkg::ST_RX_HDR)
        begin
            if (rx_take && (idx_q == cfr_pkg::OFS_PRE_HI))
            begin
                crc16_q <= cfr_pkg::CRC16_INIT;  // see RL7
            end
            else if (rx_take && (idx_q >= cfr_pkg::OFS_CRC_FRST)
                     && (idx_q <= cfr_pkg::OFS_CRC_LAST))
            begin
                crc16_q <= cfr_pkg::crc16_byte(crc16_q, rx_data_i);  // see RL6, RL7
            end
        end
    end

    // payload bytes and their checksum
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            crc32_q    <= cfr_pkg::CRC32_INIT;
            data_cnt_q <= 32'h00000000;
        end
        else if (state_q == cfr_pkg::ST_HDR_CHK)
        begin
            crc32_q    <= cfr_pkg::CRC32_INIT;  // see RL8
            data_cnt_q <= 32'h00000000;
        end
        else if (rx_take && (state_q == cfr_pkg::ST_RX_DATA))
        begin
            crc32_q    <= cfr_pkg::crc32_byte(crc32_q, rx_data_i);  // see RL8
            data_cnt_q <= data_cnt_q + 32'h00000001;
        end
    end

    // verdict; a failing frame never reaches the storage side
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            status_q   <= cfr_pkg::RES_OK;
            file_req_q <= 1'b0;
            file_sel_q <= cfr_pkg::SEL_DEPTH;
            file_len_q <= 32'h00000000;
        end
        else
        begin
            file_req_q <= 1'b0;
            if (state_q == cfr_pkg::ST_DECIDE)
            begin
                if (crc16_q != hcs_q)
                    status_q <= cfr_pkg::RES_BAD_HCS;  // see RL13
                else if (pre_q != cfr_pkg::PREAMBLE)
                    status_q <= cfr_pkg::RES_BAD_PRE;  // see RL1, RL13
                else if (ver_q != cfr_pkg::PROTO_VERSION)
                    status_q <= cfr_pkg::RES_BAD_VER;  // see RL2, RL13
                else if (!cmd_known)
                    status_q <= cfr_pkg::RES_BAD_CMD;
                else if (!flags_q[cfr_pkg::FLAG_SKIP_PCS] && (len_q != 32'h00000000)
                         && (crc32_q != pcs_q))
                    status_q <= cfr_pkg::RES_BAD_PCS;  // see RL5
                else
                begin
                    status_q   <= cfr_pkg::RES_OK;
                    file_req_q <= 1'b1;
                    file_sel_q <= cmd_q[1:0] - cfr_pkg::CMD_DEPTH_CAL[1:0];  // see RL3
                    file_len_q <= len_q;
                end
            end
        end
    end

    // response header bytes
    always_comb
    begin
        tx_byte = 8'h00;  // see RL11
        case (tx_idx_q)
            cfr_pkg::OFS_PRE_HI:   tx_byte = cfr_pkg::PREAMBLE[15:8];  // see RL1, RL12
            cfr_pkg::OFS_PRE_LO:   tx_byte = cfr_pkg::PREAMBLE[7:0];
            cfr_pkg::OFS_VERSION:  tx_byte = cfr_pkg::PROTO_VERSION;  // see RL2
            cfr_pkg::OFS_CMD:      tx_byte = cmd_q;  // see RL10
            cfr_pkg::OFS_SUBCMD:   tx_byte = sub_q;  // see RL10
            cfr_pkg::OFS_STATUS:   tx_byte = status_q;
            cfr_pkg::OFS_HCS_HI:   tx_byte = tx_crc_q[15:8];  // see RL6, RL12
            cfr_pkg::OFS_HCS_LO:   tx_byte = tx_crc_q[7:0];
            default:               tx_byte = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tx_idx_q <= 6'h00;
            tx_crc_q <= cfr_pkg::CRC16_INIT;
        end
        else if (state_q == cfr_pkg::ST_DECIDE)
        begin
            tx_idx_q <= 6'h00;
            tx_crc_q <= cfr_pkg::CRC16_INIT;  // see RL7
        end
        else if (tx_push)
        begin
            tx_idx_q <= tx_idx_q + 6'h01;
            if ((tx_idx_q >= cfr_pkg::OFS_CRC_FRST) && (tx_idx_q <= cfr_pkg::OFS_CRC_LAST))
            begin
                tx_crc_q <= cfr_pkg::crc16_byte(tx_crc_q, tx_byte);  // see RL6, RL7
            end
        end
    end

    // the buffer lets a stalled receiver hold off the builder without losing a byte
    cfr_skid_buf u_buf (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .in_data_i   (tx_byte),
        .in_valid_i  (state_q == cfr_pkg::ST_TX_RESP),
        .in_ready_o  (buf_ready),
        .out_data_o  (tx_data_o),
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i)
    );

    assign rx_ready_o = rx_ready_q;
    assign file_req_o = file_req_q;
    assign file_sel_o = file_sel_q;
    assign file_len_o = file_len_q;
    assign status_o   = status_q;

endmodule

/* File: rtl/cfr_skid_buf.sv */
// Purpose: two-entry buffer between the response builder and the receiver
// Assumes: same clock on both sides
// Notes:   output data and valid come straight from registers
module cfr_skid_buf (
    // clock and reset
    input  wire logic                          sys_clk_i,
    input  wire logic                          resetn_i,
    // filling side
    input  wire logic [cfr_pkg::BUF_WIDTH-1:0] in_data_i,
    input  wire logic                          in_valid_i,
    output logic                               in_ready_o,
    // draining side
    output logic      [cfr_pkg::BUF_WIDTH-1:0] out_data_o,
    output logic                               out_valid_o,
    input  wire logic                          out_ready_i
);

    logic [cfr_pkg::BUF_WIDTH-1:0] out_data_q;
    logic                          out_valid_q;
    logic [cfr_pkg::BUF_WIDTH-1:0] skid_data_q;
    logic                          skid_valid_q;
    logic                          push;
    logic                          load;

    // the spare slot fills only while the output stalls, so ready is a plain register term
    assign in_ready_o  = !skid_valid_q;
    assign out_data_o  = out_data_q;
    assign out_valid_o = out_valid_q;
    assign push        = in_valid_i && in_ready_o;
    assign load        = !out_valid_q || out_ready_i;

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            out_data_q  <= '0;
            out_valid_q <= 1'b0;
        end
        else if (load)
        begin
            out_data_q  <= skid_valid_q ? skid_data_q : in_data_i;
            out_valid_q <= skid_valid_q || push;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            skid_data_q  <= '0;
            skid_valid_q <= 1'b0;
        end
        else if (load)
        begin
            skid_valid_q <= 1'b0;
        end
        else if (push)
        begin
            skid_data_q  <= in_data_i;
            skid_valid_q <= 1'b1;
        end
    end

endmodule
